/* common/dio_cfg_pkg.sv */
// Constants, field layout and types of the channel configuration registers.
`default_nettype none

package dio_cfg_pkg;

  // ==========================================================================
  // Register map and reset values.
  localparam logic [7:0] DIAG_CFG_ADDR  = 8'h0C;
  localparam logic [7:0] OUT_CFG_ADDR   = 8'h0D;
  localparam logic [7:0] DIAG_CFG_RESET = 8'h08;
  localparam logic [7:0] OUT_CFG_RESET  = 8'h00;
  localparam logic [7:0] UNMAPPED_READ  = 8'h00;

  // ==========================================================================
  // Field positions.
  localparam int SUPPLY_MASK_BIT = 5;
  localparam int LEVEL_VIEW_BIT  = 4;
  localparam int ABOVE_PROT_BIT  = 3;
  localparam int STRETCH_EN_BIT  = 2;
  localparam int BLANK_SEL_LSB   = 0;
  localparam int MODE_W          = 2;
  localparam int CL_W            = 2;
  localparam int NUM_CH          = 4;

  // ==========================================================================
  // Timing, in milliseconds as printed, then in clock cycles.
  localparam int unsigned CLK_KHZ        = 200000;
  localparam int unsigned T_STRETCH_MS   = 100;
  localparam int unsigned T_BLANK_01_MS  = 8;
  localparam int unsigned T_BLANK_10_MS  = 50;
  localparam int unsigned T_BLANK_11_MS  = 300;
  localparam int unsigned T_INRUSH_00_MS = 20;
  localparam int unsigned T_INRUSH_01_MS = 50;
  localparam int unsigned T_INRUSH_10_MS = 40;
  localparam int unsigned T_INRUSH_11_MS = 10;
  localparam int unsigned STRETCH_CYC    = T_STRETCH_MS * CLK_KHZ;
  localparam int unsigned BLANK_01_CYC   = T_BLANK_01_MS * CLK_KHZ;
  localparam int unsigned BLANK_10_CYC   = T_BLANK_10_MS * CLK_KHZ;
  localparam int unsigned BLANK_11_CYC   = T_BLANK_11_MS * CLK_KHZ;
  localparam int unsigned INRUSH_00_CYC  = T_INRUSH_00_MS * CLK_KHZ;
  localparam int unsigned INRUSH_01_CYC  = T_INRUSH_01_MS * CLK_KHZ;
  localparam int unsigned INRUSH_10_CYC  = T_INRUSH_10_MS * CLK_KHZ;
  localparam int unsigned INRUSH_11_CYC  = T_INRUSH_11_MS * CLK_KHZ;
  localparam int          CNT_W          = 27;

  // ==========================================================================
  // Types.
  typedef enum logic [1:0] {
    MODE_HS        = 2'h0,
    MODE_HS_INRUSH = 2'h1,
    MODE_CLAMP_PP  = 2'h2,
    MODE_SIMPLE_PP = 2'h3
  } out_mode_t;

  typedef enum logic [1:0] {
    OVL_CLEAR    = 2'h0,
    OVL_BLANKING = 2'h1,
    OVL_SET      = 2'h2,
    OVL_HOLD     = 2'h3
  } ovl_state_t;

  typedef struct packed {
    logic                lockout;
    logic                warn;
    logic                low;
    logic [NUM_CH-1:0]   chan_ok_fault;
  } supply_faults_t;

  typedef struct packed {
    logic [NUM_CH-1:0] high_side;
    logic [NUM_CH-1:0] inrush;
    logic [NUM_CH-1:0] clamp_pp;
    logic [NUM_CH-1:0] simple_pp;
  } chan_modes_t;

endpackage

`default_nettype wire

/* hdl/ovl_filter.sv */
// Blanking and minimum-hold filter for one channel's thermal overload flag.
`default_nettype none

module ovl_filter
  import dio_cfg_pkg::*;
(
  input  wire logic             mclk_in,        // System clock.
  input  wire logic             rst_in,         // Synchronous reset.
  input  wire logic             raw_in,         // Unfiltered overload.
  input  wire logic [CNT_W-1:0] blank_len_in,   // Blanking, 0 = none.
  input  wire logic             stretch_en_in,  // Minimum hold enable.
  input  wire logic [CNT_W-1:0] stretch_len_in, // Minimum hold length.
  output logic                  flag_out        // Filtered flag.
);

  ovl_state_t       state_q;
  ovl_state_t       state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic             held_long;

  // The hold count starts at assertion, so a flag set longer than the hold
  // time drops as soon as the overload goes away.
  assign held_long = !stretch_en_in || (cnt_q >= stretch_len_in);
  assign flag_out  = (state_q == OVL_SET) || (state_q == OVL_HOLD);

  always_comb begin
    state_d = state_q;
    // The count saturates so that a very long overload cannot wrap it back
    // under the hold length and stretch the flag a second time.
    cnt_d   = (cnt_q == '1) ? cnt_q : cnt_q + CNT_W'(1);
    case (state_q)
      OVL_CLEAR: begin
        cnt_d = '0;
        if (raw_in) begin
          state_d = (blank_len_in == '0) ? OVL_SET : OVL_BLANKING;
        end
      end
      OVL_BLANKING: begin
        if (!raw_in) begin
          state_d = OVL_CLEAR;
        end else if (cnt_q + CNT_W'(1) >= blank_len_in) begin
          state_d = OVL_SET;
          cnt_d   = '0;
        end
      end
      OVL_SET: begin
        if (!raw_in) begin
          state_d = held_long ? OVL_CLEAR : OVL_HOLD;
        end
      end
      OVL_HOLD: begin
        if (raw_in) begin
          state_d = OVL_SET;
        end else if (held_long) begin
          state_d = OVL_CLEAR;
        end
      end
      default: state_d = OVL_CLEAR;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state_q <= OVL_CLEAR;
      cnt_q   <= '0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  // ==========================================================================
  // Assertions.
  AST_BLANK_NONE: assert property (@(posedge mclk_in) disable iff (rst_in)
    (!rst_in && state_q == OVL_CLEAR && raw_in && blank_len_in == '0)
    |=> flag_out)
    else $error("Overload with no blanking did not set the flag.");
  AST_BLANK_WAIT: assert property (@(posedge mclk_in) disable iff (rst_in)
    (state_q == OVL_CLEAR && raw_in && blank_len_in > CNT_W'(2))
    |=> !flag_out ##1 !flag_out)
    else $error("Overload flag set inside the blanking time.");
  AST_STRETCH_HOLD: assert property (@(posedge mclk_in) disable iff (rst_in)
    (flag_out && !raw_in && stretch_en_in && cnt_q < stretch_len_in)
    |=> flag_out)
    else $error("Stretched overload flag dropped before its hold time.");
  AST_NO_STRETCH: assert property (@(posedge mclk_in) disable iff (rst_in)
    (state_q == OVL_SET && !raw_in && !stretch_en_in) |=> !flag_out)
    else $error("Overload flag held although stretch is off.");
  COV_HOLD: cover property (@(posedge mclk_in) disable iff (rst_in)
    state_q == OVL_HOLD ##1 state_q == OVL_CLEAR);

endmodule

`default_nettype wire

/* hdl/dio_channel_config_regs.sv */
// Channel configuration registers and the channel logic that they steer.
// ============================================================================
// Overview of operation
// - Supply-fault mask removes supply faults from error flag.
// - Level view: pin level or channel supply fault.
// - Pin-level view keeps channel supply faults out.
// - Above-supply fault turns gate drive off, if enabled.
// - Stretch keeps overload flag set at least 100ms.
// - Blanking code: off, 8ms, 50ms, 300ms.
// - Blanking applies to all channels, on or off.
// - Four two-bit output mode fields, channel 1 lowest.
// - Modes: high-side, doubled inrush, clamp, simple push-pull.
// - Inrush time follows channel current-limit code.
`default_nettype none

module dio_channel_config_regs
  import dio_cfg_pkg::*;
#(
  parameter int unsigned STRETCH_CYCLES   = STRETCH_CYC,
  parameter int unsigned BLANK_01_CYCLES  = BLANK_01_CYC,
  parameter int unsigned BLANK_10_CYCLES  = BLANK_10_CYC,
  parameter int unsigned BLANK_11_CYCLES  = BLANK_11_CYC,
  parameter int unsigned INRUSH_00_CYCLES = INRUSH_00_CYC,
  parameter int unsigned INRUSH_01_CYCLES = INRUSH_01_CYC,
  parameter int unsigned INRUSH_10_CYCLES = INRUSH_10_CYC,
  parameter int unsigned INRUSH_11_CYCLES = INRUSH_11_CYC
) (
  input  wire logic              mclk_in,             // 200 MHz clock.
  input  wire logic              rst_in,              // Sync reset, high.
  input  wire logic              reg_wr_in,           // Register write.
  input  wire logic              reg_rd_in,           // Register read.
  input  wire logic [7:0]        reg_addr_in,         // Register address.
  input  wire logic [7:0]        reg_wdata_in,        // Write data.
  output logic      [7:0]        reg_rdata_out,       // Read data.
  input  wire supply_faults_t    supply_faults_in,    // Supply monitors.
  input  wire logic [NUM_CH-1:0] channel_pin_in,      // Pin logic levels.
  input  wire logic [NUM_CH-1:0] above_supply_in,     // Above-supply seen.
  input  wire logic [NUM_CH-1:0] overload_raw_in,     // Raw overloads.
  input  wire logic [NUM_CH-1:0] channel_on_in,       // Output switched on.
  input  wire logic [7:0]        current_limit_in,    // Limit codes.
  output logic                   supply_error_flag_out, // Supply error.
  output logic      [NUM_CH-1:0] channel_level_out,   // Level register.
  output logic      [NUM_CH-1:0] gate_off_out,        // pMOS gate off.
  output logic      [NUM_CH-1:0] thermal_overload_flag_out, // Overloads.
  output chan_modes_t            modes_out,           // Decoded modes.
  output logic      [NUM_CH-1:0] inrush_active_out    // Doubled current.
);

  // ==========================================================================
  // Parameter checks.
  if (STRETCH_CYCLES < 1 || BLANK_01_CYCLES < 1 || BLANK_10_CYCLES < 1 ||
      BLANK_11_CYCLES < 1 || INRUSH_00_CYCLES < 1 ||
      INRUSH_01_CYCLES < 1 || INRUSH_10_CYCLES < 1 ||
      INRUSH_11_CYCLES < 1) begin : g_bad_short
    $error("Timing counts must be at least one cycle.");
  end
  if (STRETCH_CYCLES >= (1 << CNT_W) || BLANK_01_CYCLES >= (1 << CNT_W) ||
      BLANK_10_CYCLES >= (1 << CNT_W) || BLANK_11_CYCLES >= (1 << CNT_W) ||
      INRUSH_00_CYCLES >= (1 << CNT_W) ||
      INRUSH_01_CYCLES >= (1 << CNT_W) ||
      INRUSH_10_CYCLES >= (1 << CNT_W) ||
      INRUSH_11_CYCLES >= (1 << CNT_W)) begin : g_bad_long
    $error("Timing counts exceed the counter width.");
  end

  // ==========================================================================
  // Register port.
  logic [7:0] diag_cfg_q;
  logic [7:0] out_cfg_q;
  logic [7:0] rdata_q;
  wire        wr_diag = reg_wr_in && (reg_addr_in == DIAG_CFG_ADDR);
  wire        wr_out  = reg_wr_in && (reg_addr_in == OUT_CFG_ADDR);
  wire        rd_diag = reg_addr_in == DIAG_CFG_ADDR;
  wire        rd_out  = reg_addr_in == OUT_CFG_ADDR;
  wire [7:0]  rd_mux  = rd_diag ? diag_cfg_q :
                        rd_out  ? out_cfg_q  : UNMAPPED_READ;

  // Full bytes are kept so that every field reads back as written.
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      diag_cfg_q <= DIAG_CFG_RESET;
      out_cfg_q  <= OUT_CFG_RESET;
      rdata_q    <= UNMAPPED_READ;
    end else begin
      if (wr_diag) begin
        diag_cfg_q <= reg_wdata_in;
      end
      if (wr_out) begin
        out_cfg_q <= reg_wdata_in;
      end
      if (reg_rd_in) begin
        rdata_q <= rd_mux;
      end
    end
  end
  assign reg_rdata_out = rdata_q;

  // ==========================================================================
  // Supply error and level view.
  wire       supply_mask = diag_cfg_q[SUPPLY_MASK_BIT];
  wire       level_view  = diag_cfg_q[LEVEL_VIEW_BIT];
  wire       above_prot  = diag_cfg_q[ABOVE_PROT_BIT];
  wire       stretch_en  = diag_cfg_q[STRETCH_EN_BIT];
  wire [1:0] blank_sel   = diag_cfg_q[BLANK_SEL_LSB +: 2];
  // Channel supply faults only reach the error flag in the fault view.
  wire       chan_supply = level_view &&
                           |supply_faults_in.chan_ok_fault;
  wire       supply_any  = supply_faults_in.lockout ||
                           supply_faults_in.warn || supply_faults_in.low ||
                           chan_supply;
  wire       supply_d    = !supply_mask && supply_any;
  wire [NUM_CH-1:0] level_d = level_view ? supply_faults_in.chan_ok_fault
                                         : channel_pin_in;
  wire [NUM_CH-1:0] gate_off_d = above_prot ? above_supply_in
                                            : '0;

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      supply_error_flag_out <= 1'b0;
      channel_level_out     <= '0;
      gate_off_out          <= '0;
    end else begin
      supply_error_flag_out <= supply_d;
      channel_level_out     <= level_d;
      gate_off_out          <= gate_off_d;
    end
  end

  // ==========================================================================
  // Overload blanking, shared by all channels whatever their state.
  wire [CNT_W-1:0] blank_len =
    (blank_sel == 2'h1) ? CNT_W'(BLANK_01_CYCLES) :
    (blank_sel == 2'h2) ? CNT_W'(BLANK_10_CYCLES) :
    (blank_sel == 2'h3) ? CNT_W'(BLANK_11_CYCLES) : '0;

  // ==========================================================================
  // Per-channel mode decode, overload filter and inrush timer.
  logic [CNT_W-1:0] inrush_cnt_q [NUM_CH];
  logic [NUM_CH-1:0] on_prev_q;
  logic [NUM_CH-1:0] inrush_start;
  logic [NUM_CH-1:0] is_hs;
  logic [NUM_CH-1:0] is_inrush;
  logic [NUM_CH-1:0] is_clamp;
  logic [NUM_CH-1:0] is_simple;

  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
    out_mode_t        mode;
    logic [CL_W-1:0]  cl_code;
    logic [CNT_W-1:0] inrush_len;

    assign mode    = out_mode_t'(out_cfg_q[ch*MODE_W +: MODE_W]);
    assign cl_code = current_limit_in[ch*CL_W +: CL_W];
    assign inrush_len =
      (cl_code == 2'h0) ? CNT_W'(INRUSH_00_CYCLES) :
      (cl_code == 2'h1) ? CNT_W'(INRUSH_01_CYCLES) :
      (cl_code == 2'h2) ? CNT_W'(INRUSH_10_CYCLES) :
                          CNT_W'(INRUSH_11_CYCLES);
    assign inrush_start[ch] = channel_on_in[ch] && !on_prev_q[ch] &&
                              (mode == MODE_HS_INRUSH);

    assign is_hs[ch]     = (mode == MODE_HS);
    assign is_inrush[ch] = (mode == MODE_HS_INRUSH);
    assign is_clamp[ch]  = (mode == MODE_CLAMP_PP);
    assign is_simple[ch] = (mode == MODE_SIMPLE_PP);

    // Leaving the inrush mode or switching off ends the doubled current.
    always_ff @(posedge mclk_in) begin
      if (rst_in) begin
        inrush_cnt_q[ch] <= '0;
      end else if (inrush_start[ch]) begin
        inrush_cnt_q[ch] <= inrush_len;
      end else if (!channel_on_in[ch] || mode != MODE_HS_INRUSH) begin
        inrush_cnt_q[ch] <= '0;
      end else if (inrush_cnt_q[ch] != '0) begin
        inrush_cnt_q[ch] <= inrush_cnt_q[ch] - CNT_W'(1);
      end
    end
    assign inrush_active_out[ch] = inrush_cnt_q[ch] != '0;

    ovl_filter u_ovl (
      .mclk_in        (mclk_in),
      .rst_in         (rst_in),
      .raw_in         (overload_raw_in[ch]),
      .blank_len_in   (blank_len),
      .stretch_en_in  (stretch_en),
      .stretch_len_in (CNT_W'(STRETCH_CYCLES)),
      .flag_out       (thermal_overload_flag_out[ch])
    );
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      on_prev_q           <= '0;
      modes_out.high_side <= '1;
      modes_out.inrush    <= '0;
      modes_out.clamp_pp  <= '0;
      modes_out.simple_pp <= '0;
    end else begin
      on_prev_q           <= channel_on_in;
      modes_out.high_side <= is_hs;
      modes_out.inrush    <= is_inrush;
      modes_out.clamp_pp  <= is_clamp;
      modes_out.simple_pp <= is_simple;
    end
  end

  // ==========================================================================
  // Assertions.
  AST_SUPPLY_MASK: assert property (@(posedge mclk_in) disable iff (rst_in)
    supply_mask |=> !supply_error_flag_out)
    else $error("Masked supply fault reached the error flag.");
  AST_SUPPLY_SET: assert property (@(posedge mclk_in) disable iff (rst_in)
    (!rst_in && !supply_mask && supply_faults_in.lockout)
    |=> supply_error_flag_out)
    else $error("Unmasked lockout did not set the error flag.");
  AST_CHAN_EXCLUDED: assert property (@(posedge mclk_in) disable iff (rst_in)
    (!level_view && !supply_faults_in.lockout && !supply_faults_in.warn &&
     !supply_faults_in.low) |=> !supply_error_flag_out)
    else $error("Channel supply fault set the flag in pin view.");
  AST_LEVEL_VIEW: assert property (@(posedge mclk_in) disable iff (rst_in)
    !rst_in |=> channel_level_out == ($past(level_view) ?
      $past(supply_faults_in.chan_ok_fault)
      : $past(channel_pin_in)))
    else $error("Level register shows the wrong source.");
  AST_GATE_OFF: assert property (@(posedge mclk_in) disable iff (rst_in)
    (!rst_in && above_prot && above_supply_in[0])
    |=> gate_off_out[0])
    else $error("Above-supply fault left the gate drive on.");
  AST_GATE_IDLE: assert property (@(posedge mclk_in) disable iff (rst_in)
    !above_prot |=> gate_off_out == '0)
    else $error("Gate drive turned off with protection disabled.");
  AST_WRITE_BACK: assert property (@(posedge mclk_in) disable iff (rst_in)
    (wr_diag ##1 !wr_diag ##1 (reg_rd_in && rd_diag))
    |=> reg_rdata_out == $past(reg_wdata_in, 3))
    else $error("Diagnostic register did not read back as written.");
  AST_READ_BACK: assert property (@(posedge mclk_in) disable iff (rst_in)
    (wr_out ##1 !wr_out ##1 (reg_rd_in && rd_out))
    |=> reg_rdata_out == $past(reg_wdata_in, 3))
    else $error("Output mode register did not read back as written.");
  AST_RESET_MODE: assert property (@(posedge mclk_in) disable iff (rst_in)
    $fell(rst_in) |-> out_cfg_q == OUT_CFG_RESET)
    else $error("Output modes not high-side after reset.");
  AST_MODE_CH4: assert property (@(posedge mclk_in) disable iff (rst_in)
    wr_out ##1 !wr_out |=> modes_out.simple_pp[3] ==
      ($past(reg_wdata_in[7:6], 2) == 2'h3))
    else $error("Channel 4 mode not decoded from bits 7:6.");
  AST_INRUSH_LEN: assert property (@(posedge mclk_in) disable iff (rst_in)
    inrush_start[0] |=> inrush_cnt_q[0] == $past(g_ch[0].inrush_len))
    else $error("Inrush timer loaded with the wrong length.");
  COV_INRUSH: cover property (@(posedge mclk_in) disable iff (rst_in)
    inrush_start[1] ##1 inrush_active_out[1]);
  COV_SUPPLY: cover property (@(posedge mclk_in) disable iff (rst_in)
    level_view && !supply_mask ##1 supply_error_flag_out);
  COV_OVL: cover property (@(posedge mclk_in) disable iff (rst_in)
    $rose(thermal_overload_flag_out[2]));

endmodule

`default_nettype wire

/* dv/tb.sv */
// Self-checking testbench for the channel configuration register block.
`default_nettype none

module tb;
  import dio_cfg_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Clock, stimulus signals and the design.
  localparam int B1 = 8;
  localparam int B2 = 12;
  localparam int B3 = 30;
  typedef struct packed {
    logic [2:0]  kind;
    logic [15:0] val;
  } note_t;

  logic           mclk_in  = 1'b0;
  logic           rst_in   = 1'b1;
  logic           wr_q     = 1'b0;
  logic           rd_q     = 1'b0;
  logic           obs_q    = 1'b0;
  logic           seen_q   = 1'b0;
  logic [7:0]     addr_q   = 8'h00;
  logic [7:0]     wdata_q  = 8'h00;
  supply_faults_t sf_q     = '0;
  logic [3:0]     pins_q   = 4'h0;
  logic [3:0]     above_q  = 4'h0;
  logic [3:0]     raw_q    = 4'h0;
  logic [3:0]     on_q     = 4'h0;
  logic [7:0]     cl_q     = 8'h00;
  logic [31:0]    seed     = 32'h66E40C74;
  logic [7:0]     rdata;
  logic           serr;
  logic [3:0]     level;
  logic [3:0]     gate;
  logic [3:0]     ovl;
  logic [3:0]     inrush;
  chan_modes_t    modes;
  note_t          notes[$];
  int             fail_count = 0;
  int             n_compared = 0;

  always #2.5 mclk_in = ~mclk_in;

  dio_channel_config_regs #(
    .STRETCH_CYCLES(20), .BLANK_01_CYCLES(B1), .BLANK_10_CYCLES(B2),
    .BLANK_11_CYCLES(B3), .INRUSH_00_CYCLES(10), .INRUSH_01_CYCLES(16),
    .INRUSH_10_CYCLES(14), .INRUSH_11_CYCLES(6)
  ) DUT (
    .mclk_in(mclk_in), .rst_in(rst_in), .reg_wr_in(wr_q), .reg_rd_in(rd_q),
    .reg_addr_in(addr_q), .reg_wdata_in(wdata_q), .reg_rdata_out(rdata),
    .supply_faults_in(sf_q), .channel_pin_in(pins_q),
    .above_supply_in(above_q), .overload_raw_in(raw_q),
    .channel_on_in(on_q), .current_limit_in(cl_q),
    .supply_error_flag_out(serr), .channel_level_out(level),
    .gate_off_out(gate), .thermal_overload_flag_out(ovl),
    .modes_out(modes), .inrush_active_out(inrush)
  );

  // ==========================================================================
  // Helpers and bus tasks.
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic chan_modes_t expm(input logic [7:0] v);
    chan_modes_t m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      case (v[2*i+:2])
        2'h0: m.high_side[i] = 1'b1;
        2'h1: m.inrush[i] = 1'b1;
        2'h2: m.clamp_pp[i] = 1'b1;
        default: m.simple_pp[i] = 1'b1;
      endcase
    end
    return m;
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    wr_q <= 1'b1;
    addr_q <= a;
    wdata_q <= d;
    @(posedge mclk_in);
    wr_q <= 1'b0;
  endtask

  // The expected read value is noted before the strobe is raised.
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk_in);
    notes.push_back({3'd0, 8'h00, e});
    rd_q <= 1'b1;
    addr_q <= a;
    @(posedge mclk_in);
    rd_q <= 1'b0;
  endtask

  task automatic chk(input logic [2:0] k, input logic [15:0] v);
    @(posedge mclk_in);
    notes.push_back({k, v});
    obs_q <= 1'b1;
    @(posedge mclk_in);
    obs_q <= 1'b0;
  endtask

  task automatic cmp8(input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch at %0t: read data %h, expected %h", $time, g, e);
    end
  endtask

  task automatic cmp4(input logic [2:0] k, input logic [3:0] e,
                      input logic [3:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch at %0t: status %0d is %h, expected %h",
               $time, k, g, e);
    end
  endtask

  task automatic cmpm(input chan_modes_t e, input chan_modes_t g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch at %0t: modes %h, expected %h", $time, g, e);
    end
  endtask

  task automatic finish_test();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // ==========================================================================
  // Monitor: a result appears one edge after a read or a look is taken.
  always @(posedge mclk_in) seen_q <= rd_q | obs_q;

  always @(negedge mclk_in) begin
    note_t n;
    if (seen_q) begin
      if (notes.size() == 0) begin
        fail_count++;
        $display("mismatch at %0t: result with no note", $time);
      end else begin
        n = notes.pop_front();
        case (n.kind)
          3'd0: cmp8(n.val[7:0], rdata);
          3'd1: cmp4(n.kind, n.val[3:0], {3'b000, serr});
          3'd2: cmp4(n.kind, n.val[3:0], level);
          3'd3: cmp4(n.kind, n.val[3:0], gate);
          3'd4: cmp4(n.kind, n.val[3:0], ovl);
          3'd5: cmpm(chan_modes_t'(n.val), modes);
          default: cmp4(n.kind, n.val[3:0], inrush);
        endcase
      end
    end
  end

  initial begin
    tick(6000);
    fail_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    finish_test();
  end

  // ==========================================================================
  // Scenarios.
  initial begin
    logic [31:0] r;
    logic [7:0]  v;
    int          bl;
    logic        e1;
    tick(2);
    rst_in <= 1'b0;
    rd(DIAG_CFG_ADDR, DIAG_CFG_RESET);
    rd(OUT_CFG_ADDR, 8'h00);
    chk(3'd5, expm(8'h00));
    rd(8'h0E, UNMAPPED_READ);
    for (int i = 0; i < 7; i++) begin
      r = xs();
      v = (i < 4) ? 8'h55 * i[7:0] : r[7:0];
      wr(OUT_CFG_ADDR, v);
      rd(OUT_CFG_ADDR, v);
      chk(3'd5, expm(v));
    end
    r = xs();
    wr(DIAG_CFG_ADDR, r[7:0]);
    rd(DIAG_CFG_ADDR, r[7:0]);
    for (int i = 0; i < 8; i++) begin
      r = xs();
      wr(DIAG_CFG_ADDR, {2'b00, i[0], i[1], i[2], 3'b000});
      sf_q <= supply_faults_t'(r[6:0]);
      pins_q <= r[10:7];
      above_q <= r[14:11];
      e1 = ~i[0] & (|r[6:4] | (i[1] & |r[3:0]));
      chk(3'd1, {15'h0, e1});
      chk(3'd2, i[1] ? r[3:0] : r[10:7]);
      chk(3'd3, i[2] ? r[14:11] : 4'h0);
    end
    r = xs();
    on_q <= r[3:0];
    for (int b = 0; b < 4; b++) begin
      bl = (b == 0) ? 0 : (b == 1) ? B1 : (b == 2) ? B2 : B3;
      wr(DIAG_CFG_ADDR, 8'h08 | b[7:0]);
      @(posedge mclk_in);
      raw_q <= 4'hF;
      if (bl > 0) begin
        tick(bl / 2 - 2);
        chk(3'd4, 4'h0);
        tick(bl / 2 + 2);
      end
      chk(3'd4, 4'hF);
      @(posedge mclk_in);
      raw_q <= 4'h0;
      tick(2);
      chk(3'd4, 4'h0);
      if (bl > 0) begin
        raw_q <= 4'hF;
        tick(bl / 2 - 1);
        raw_q <= 4'h0;
        tick(bl);
        chk(3'd4, 4'h0);
      end
    end
    wr(DIAG_CFG_ADDR, 8'h0C);
    @(posedge mclk_in);
    raw_q <= 4'hF;
    tick(2);
    raw_q <= 4'h0;
    tick(8);
    chk(3'd4, 4'hF);
    tick(18);
    chk(3'd4, 4'h0);
    on_q <= 4'h0;
    cl_q <= 8'h63;
    wr(OUT_CFG_ADDR, 8'h55);
    tick(2);
    on_q <= 4'hF;
    tick(2);
    chk(3'd6, 4'hF);
    tick(4);
    chk(3'd6, 4'hE);
    tick(2);
    chk(3'd6, 4'hC);
    tick(6);
    chk(3'd6, 4'h0);
    wr(OUT_CFG_ADDR, 8'hFF);
    rst_in <= 1'b1;
    tick(2);
    rst_in <= 1'b0;
    rd(OUT_CFG_ADDR, 8'h00);
    tick(3);
    finish_test();
  end

endmodule

`default_nettype wire
